/* common/arc_pkg.sv */
// shared constants and types for the converter register and control block
package arc_pkg;
  // register byte addresses and the reset read value
  localparam logic [7:0] ARC_RES_LOW_OFS  = 8'h78;
  localparam logic [7:0] ARC_RES_HIGH_OFS = 8'h79;
  localparam logic [7:0] ARC_CTRL_OFS     = 8'h7a;
  localparam logic [7:0] ARC_TRIG_OFS     = 8'h7b;
  localparam logic [7:0] ARC_MUX_OFS      = 8'h7c;
  localparam logic [7:0] ARC_DIS_OFS      = 8'h7e;
  localparam logic [7:0] ARC_RST_VAL      = 8'h00;
  // control register bit positions
  localparam int ARC_EN_BIT    = 7;
  localparam int ARC_START_BIT = 6;
  localparam int ARC_ATE_BIT   = 5;
  localparam int ARC_FLAG_BIT  = 4;
  localparam int ARC_IE_BIT    = 3;
  // multiplexer register fields, and the trigger register's comparator mux enable bit
  localparam int ARC_REF_LSB   = 6;
  localparam int ARC_LJ_BIT    = 5;
  localparam int ARC_CME_BIT   = 6;
  // conversion lengths in converter clock cycles
  localparam logic [4:0] ARC_FIRST_CYC = 5'd25;
  localparam logic [4:0] ARC_NORM_CYC  = 5'd13;
  // free running trigger code
  localparam logic [2:0] ARC_TS_FREE   = 3'b000;
  // reference codes
  localparam logic [1:0] ARC_REF_EXT   = 2'b00;
  localparam logic [1:0] ARC_REF_AVCC  = 2'b01;
  localparam logic [1:0] ARC_REF_INT   = 2'b11;
  // channel codes beyond the pins
  localparam logic [3:0] ARC_CH_BANDGAP = 4'b1110;
  localparam logic [3:0] ARC_CH_GROUND  = 4'b1111;
  // settings handed to the analog core
  typedef struct packed {
    logic       power;    // converter powered
    logic [1:0] ref_sel;  // reference code
    logic [3:0] channel;  // input code
  } arc_core_s;
endpackage : arc_pkg

/* design/arc_top.sv */
// converter register file, prescaler, conversion sequencer and triggers
`timescale 1ns/1ps
`default_nettype none
module arc_top (
  input  wire logic              ref_clk_i,      // system clock
  input  wire logic              rst_i,          // async reset, high
  input  wire logic [7:0]        addr_i,         // register address
  input  wire logic [7:0]        wdata_i,        // write data
  input  wire logic              wr_i,           // write strobe
  input  wire logic              rd_i,           // read strobe
  output logic      [7:0]        rdata_o,        // read data
  input  wire logic [9:0]        core_result_i,  // core result
  input  wire logic [7:1]        trig_flags_i,   // trigger source flags
  input  wire logic              irq_ack_i,      // vector taken
  input  wire logic              global_ie_i,    // global int enable
  output logic                   irq_o,          // interrupt request
  output arc_pkg::arc_core_s     core_ctl_o,     // core settings
  output logic                   conv_busy_o,    // conversion running
  output logic                   conv_tick_o,    // converter clock tick
  input  wire logic [5:0]        pin_raw_i,      // raw pin levels
  output logic      [5:0]        pin_value_o,    // pin read values
  output logic      [5:0]        buf_off_o       // input buffer off
);
  import arc_pkg::*;

  // prescaler terminal count for a divider code
  function automatic logic [6:0] div_last(input logic [2:0] code);
    logic [7:0] d;
    d = (code <= 3'd1) ? 8'd2 : (8'd1 << code);
    return 7'(d - 8'd1);
  endfunction

  // software registers
  logic [1:0] ref_reg;     // reference code
  logic       lj_reg;      // left justify
  logic [3:0] ch_reg;      // channel code
  logic       en_reg;      // converter enable
  logic       ate_reg;     // auto trigger enable
  logic       flag_reg;    // completion flag
  logic       ie_reg;      // completion irq enable
  logic [2:0] ps_reg;      // divider code
  logic       cme_reg;     // comparator mux enable
  logic [2:0] ts_reg;      // trigger source
  logic [5:0] dis_reg;     // input disables
  // sequencer state
  logic       pend_reg;    // start requested
  logic       busy_reg;    // conversion running
  logic       first_reg;   // next one initialises
  logic [4:0] cnt_reg;     // cycles left
  logic [6:0] pre_reg;     // prescaler count
  logic [9:0] res_reg;     // held result
  logic       lock_reg;    // result update blocked
  logic       sel_reg;     // last selected trigger
  logic       tick_reg;    // tick for output

  // bus decode
  wire wr_ctrl = wr_i && (addr_i == ARC_CTRL_OFS);
  wire wr_mux  = wr_i && (addr_i == ARC_MUX_OFS);
  wire wr_trig = wr_i && (addr_i == ARC_TRIG_OFS);
  wire wr_dis  = wr_i && (addr_i == ARC_DIS_OFS);
  wire rd_low  = rd_i && (addr_i == ARC_RES_LOW_OFS);
  wire rd_high = rd_i && (addr_i == ARC_RES_HIGH_OFS);

  // enable as it stands after this cycle
  wire en_next = wr_ctrl ? wdata_i[ARC_EN_BIT] : en_reg;
  wire off_w   = wr_ctrl && !wdata_i[ARC_EN_BIT];

  // converter clock tick from the prescaler
  wire tick_w  = en_reg && (pre_reg == div_last(ps_reg));

  // conversion start and end
  wire start_w = pend_reg && !busy_reg && tick_w && !off_w;
  wire done_w  = busy_reg && tick_w && (cnt_reg == 5'd1) && !off_w;
  wire free_w  = ate_reg && (ts_reg == ARC_TS_FREE);
  wire again_w = done_w && free_w;

  // trigger levels by code; slot zero is free running and never rises
  wire [7:0] trig_all_w = {trig_flags_i, 1'b0};
  // selected trigger level, no out-of-range index for code zero
  wire sel_w   = trig_all_w[ts_reg];
  // a switch of source also makes an edge here
  wire edge_w  = ate_reg && en_reg && sel_w && !sel_reg;
  // software start, one written with enable
  wire sw_go   = wr_ctrl && wdata_i[ARC_START_BIT] && wdata_i[ARC_EN_BIT];

  // result byte layouts
  wire [7:0] high_w = lj_reg ? res_reg[9:2] : {6'h00, res_reg[9:8]};
  wire [7:0] low_w  = lj_reg ? {res_reg[1:0], 6'h00} : res_reg[7:0];

  // register readback; reserved bits read zero
  wire [7:0] ctrl_w = {en_reg, busy_reg | pend_reg, ate_reg, flag_reg,
                       ie_reg, ps_reg};
  wire [7:0] mux_w  = {ref_reg, lj_reg, 1'b0, ch_reg};
  wire [7:0] trig_w = {1'b0, cme_reg, 3'b000, ts_reg};
  wire [7:0] dis_w  = {2'b00, dis_reg};
  wire [7:0] rd_w   = (addr_i == ARC_RES_LOW_OFS)  ? low_w  :
                      (addr_i == ARC_RES_HIGH_OFS) ? high_w :
                      (addr_i == ARC_CTRL_OFS)     ? ctrl_w :
                      (addr_i == ARC_TRIG_OFS)     ? trig_w :
                      (addr_i == ARC_MUX_OFS)      ? mux_w  :
                      (addr_i == ARC_DIS_OFS)      ? dis_w  : ARC_RST_VAL;

  // settings to the core: follow registers while idle, hold in a run
  wire        take_w   = !busy_reg || again_w;
  arc_core_s  ctl_next;
  // one driver for the whole struct: power, reference, channel
  assign ctl_next = {en_reg,
                     take_w ? ref_reg : core_ctl_o.ref_sel,
                     take_w ? ch_reg  : core_ctl_o.channel};

  // flag: hardware set beats any clear
  wire flag_clr  = irq_ack_i || (wr_ctrl && wdata_i[ARC_FLAG_BIT]);
  wire flag_next = done_w || (flag_reg && !flag_clr);

  // pending start request
  wire pend_next = !en_next ? 1'b0 :
                   (sw_go || edge_w) ? 1'b1 :
                   start_w ? 1'b0 : pend_reg;

  // conversion counter
  wire [4:0] cnt_next = start_w ? (first_reg ? ARC_FIRST_CYC : ARC_NORM_CYC) :
                        again_w ? ARC_NORM_CYC :
                        (busy_reg && tick_w) ? 5'(cnt_reg - 5'd1) : cnt_reg;

  // multiplexer and reference register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_reg <= 2'b00;
      lj_reg  <= 1'b0;
      ch_reg  <= 4'h0;
    end else if (wr_mux) begin
      ref_reg <= wdata_i[7:ARC_REF_LSB];
      lj_reg  <= wdata_i[ARC_LJ_BIT];
      ch_reg  <= wdata_i[3:0];
    end
  end

  // control register fields written by software
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg  <= 1'b0;
      ate_reg <= 1'b0;
      ie_reg  <= 1'b0;
      ps_reg  <= 3'b000;
    end else if (wr_ctrl) begin
      en_reg  <= wdata_i[ARC_EN_BIT];
      ate_reg <= wdata_i[ARC_ATE_BIT];
      ie_reg  <= wdata_i[ARC_IE_BIT];
      ps_reg  <= wdata_i[2:0];
    end
  end

  // trigger control and input disable registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cme_reg <= 1'b0;
      ts_reg  <= 3'b000;
      dis_reg <= 6'h00;
    end else begin
      if (wr_trig) begin
        cme_reg <= wdata_i[ARC_CME_BIT];
        ts_reg  <= wdata_i[2:0];
      end
      if (wr_dis) begin
        dis_reg <= wdata_i[5:0];
      end
    end
  end

  // prescaler: held at zero while off, restarts on enable
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reg <= 7'h00;
    end else if (!en_reg || tick_w) begin
      pre_reg <= 7'h00;
    end else begin
      pre_reg <= 7'(pre_reg + 7'd1);
    end
  end

  // sequencer state
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      first_reg <= 1'b1;
      cnt_reg   <= 5'h00;
      sel_reg   <= 1'b0;
    end else begin
      pend_reg  <= pend_next;
      // abort on power off, run from start to done
      busy_reg  <= off_w ? 1'b0 : (start_w || again_w) ? 1'b1 :
                   done_w ? 1'b0 : busy_reg;
      // initialisation is due again after every power off
      first_reg <= !en_next ? 1'b1 : start_w ? 1'b0 : first_reg;
      cnt_reg   <= off_w ? 5'h00 : cnt_next;
      sel_reg   <= sel_w;
    end
  end

  // result capture and read lock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_reg  <= 10'h000;
      lock_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      if (done_w && !lock_reg) begin
        res_reg <= core_result_i;
      end
      lock_reg <= rd_low ? 1'b1 : rd_high ? 1'b0 : lock_reg;
      flag_reg <= flag_next;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o     <= ARC_RST_VAL;
      irq_o       <= 1'b0;
      core_ctl_o  <= '0;
      conv_busy_o <= 1'b0;
      tick_reg    <= 1'b0;
      pin_value_o <= 6'h00;
      buf_off_o   <= 6'h00;
    end else begin
      rdata_o     <= rd_i ? rd_w : ARC_RST_VAL;
      irq_o       <= flag_reg && ie_reg && global_ie_i;
      core_ctl_o  <= ctl_next;
      conv_busy_o <= busy_reg;
      tick_reg    <= tick_w;
      pin_value_o <= pin_raw_i & ~dis_reg;
      buf_off_o   <= dis_reg;
    end
  end
  assign conv_tick_o = tick_reg;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence conv_begin_s;
    start_w && first_reg;
  endsequence
  sequence conv_run_s;
    busy_reg && !done_w && !off_w;
  endsequence

  setting_hold_a: assert property (conv_run_s |=> $stable(core_ctl_o))
    else $error("core settings changed mid conversion");
  mux_bit4_a: assert property (rd_i && addr_i == ARC_MUX_OFS |=> !rdata_o[4])
    else $error("mux bit 4 read nonzero");
  power_off_a: assert property (off_w |=> !busy_reg && !pend_reg ##1 !core_ctl_o.power)
    else $error("power off did not abort");
  first_len_a: assert property (conv_begin_s |=> cnt_reg == ARC_FIRST_CYC)
    else $error("first conversion length wrong");
  norm_len_a: assert property (start_w && !first_reg |=> cnt_reg == ARC_NORM_CYC)
    else $error("normal conversion length wrong");
  start_read_a: assert property (rd_i && addr_i == ARC_CTRL_OFS
                                 |=> rdata_o[6] == $past(busy_reg || pend_reg))
    else $error("start bit readback wrong");
  trig_edge_a: assert property (edge_w && !off_w |=> pend_reg || busy_reg)
    else $error("trigger edge lost");
  free_code_a: assert property (ts_reg == ARC_TS_FREE |-> !edge_w)
    else $error("free running code made a trigger");
  flag_set_a: assert property (done_w |=> flag_reg)
    else $error("flag not set at completion");
  irq_gate_a: assert property (flag_reg && ie_reg && global_ie_i |=> irq_o)
    else $error("interrupt request missing");
  flag_clr_a: assert property (irq_ack_i && !done_w |=> !flag_reg)
    else $error("flag not cleared by vector");
  lock_hold_a: assert property (lock_reg && !rd_high |=> $stable(res_reg))
    else $error("locked result changed");
  div_two_a: assert property (tick_w && ps_reg <= 3'd1 ##1 en_reg && $stable(ps_reg) && !wr_ctrl
                              |=> tick_w)
    else $error("divide by two tick missing");
  pin_zero_a: assert property (dis_reg[0] |=> !pin_value_o[0])
    else $error("disabled pin reads one");
  restart_a: assert property (again_w |=> busy_reg && cnt_reg == ARC_NORM_CYC)
    else $error("free running did not restart");

  // a low-byte read is the first step of a locked pair read
  sequence low_read_s;
    rd_low;
  endsequence
  // the matching high-byte read releases the pair
  sequence high_read_s;
    rd_high;
  endsequence
  // control write with start low while nothing is running or pending
  sequence idle_zero_s;
    wr_ctrl && !wdata_i[ARC_START_BIT] && !busy_reg && !pend_reg && !edge_w;
  endsequence

  // pair lock steps
  lock_set_a: assert property (low_read_s |=> lock_reg)
    else $error("low byte read did not lock");
  lock_free_a: assert property (high_read_s |=> !lock_reg)
    else $error("high byte read did not unlock");
  // start bit, busy and power-on behaviour
  zero_start_a: assert property (idle_zero_s |=> !pend_reg && !busy_reg)
    else $error("zero start bit began a conversion");
  busy_start_a: assert property (start_w |=> busy_reg && ctrl_w[ARC_START_BIT])
    else $error("start bit not busy after start");
  done_idle_a: assert property (done_w && !again_w |=> !busy_reg)
    else $error("busy stayed after completion");
  cnt_range_a: assert property (busy_reg |-> cnt_reg != 5'd0 && cnt_reg <= ARC_FIRST_CYC)
    else $error("conversion counter out of range");
  power_on_a: assert property (wr_ctrl && wdata_i[ARC_EN_BIT] |=> ##1 core_ctl_o.power)
    else $error("core not powered after enable");
  // flag, interrupt and auto trigger gating
  flag_keep_a: assert property (flag_reg && !flag_clr |=> flag_reg)
    else $error("flag lost without a clear");
  irq_low_a: assert property (!(flag_reg && ie_reg && global_ie_i) |=> !irq_o)
    else $error("interrupt request without its gates");
  ate_off_a: assert property (!ate_reg |-> !edge_w)
    else $error("trigger edge with auto trigger off");
  // result presentation
  left_now_a: assert property (wr_mux && wdata_i[ARC_LJ_BIT] |=> high_w == res_reg[9:2])
    else $error("left justify not applied at once");
  right_pad_a: assert property (!lj_reg |-> high_w[7:2] == 6'h00 && low_w == res_reg[7:0])
    else $error("right aligned layout wrong");
endmodule // arc_top
`default_nettype wire

/* tb/arc_core_model.sv */
// behavioural analog core that answers the block's core settings
`timescale 1ns/1ps
`default_nettype none
module arc_core_model
  import arc_pkg::*;
(
  input  wire arc_pkg::arc_core_s core_ctl_i,     // settings from the block
  input  wire logic               ref_clk_i,      // system clock
  output logic [9:0]              core_result_o   // conversion value
);
  logic [9:0] junk_reg = 10'h2aa;                 // pattern while powered down
  // an unpowered core shows a value that changes every cycle
  always @(posedge ref_clk_i) begin
    junk_reg <= ~junk_reg;
  end
  // powered result encodes the frozen channel and reference
  assign core_result_o = core_ctl_i.power ?
    {core_ctl_i.channel, core_ctl_i.ref_sel, 4'h5} : junk_reg;
endmodule // arc_core_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking testbench for the converter register and control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import arc_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0, gie = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
  logic [9:0] res, e;                              // core value, expected result
  logic [7:1] trig = 7'h00;                        // trigger source levels
  logic [5:0] raw = 6'h2a, pval, boff;             // pin levels
  logic       irq, busy, tick;
  arc_core_s  ctl;
  int         error_cnt = 0, num_checks = 0, n, dv;
  always #5 clk = ~clk;
  arc_top i_arc_top (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .core_result_i(res), .trig_flags_i(trig), .irq_ack_i(ack),
    .global_ie_i(gie), .irq_o(irq), .core_ctl_o(ctl), .conv_busy_o(busy),
    .conv_tick_o(tick), .pin_raw_i(raw), .pin_value_o(pval), .buf_off_o(boff));
  arc_core_model i_arc_core_model (.core_ctl_i(ctl), .ref_clk_i(clk), .core_result_o(res));
  // compare one byte-sized result
  task automatic chk8(input logic [7:0] g, input logic [7:0] x, input string m);
    num_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, x);
    end
  endtask
  // one-cycle register write
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle register read, data taken in the following cycle
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // wait a bounded time for a conversion to begin
  task automatic wbusy();
    for (int k = 0; k < 400 && busy !== 1'b1; k++) @(posedge clk);
  endtask
  // count the cycles of one whole conversion
  task automatic meas(output int c);
    c = 0;
    wbusy();
    while (busy === 1'b1 && c < 30000) begin
      @(posedge clk);
      c++;
    end
  endtask
  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // reset values and unmapped addresses; low byte first so the pair ends unlocked
    for (int i = 0; i < 8; i++) begin
      rd8(8'h78 + 8'(i), v);
      chk8(v, ARC_RST_VAL, "reset value");
    end
    // every channel and reference code, reserved bit kept zero
    for (int i = 0; i < 16; i++) begin
      wr8(ARC_MUX_OFS, {2'(i), 2'b11, 4'(i)});
      rd8(ARC_MUX_OFS, v);
      chk8(v, {2'(i), 2'b10, 4'(i)}, "mux readback");
      chk8({2'b00, ctl.ref_sel, ctl.channel}, {2'b00, 2'(i), 4'(i)}, "core codes");
    end
    // every divider: first conversion then a normal one
    for (int c = 0; c < 8; c++) begin
      dv = (c < 2) ? 2 : (1 << c);
      wr8(ARC_CTRL_OFS, {5'b11010, 3'(c)});
      meas(n);
      chk8(8'(n == 25 * dv), 8'h01, "first length");
      wr8(ARC_CTRL_OFS, {5'b11010, 3'(c)});
      meas(n);
      chk8(8'(n == 13 * dv), 8'h01, "normal length");
      rd8(ARC_CTRL_OFS, v);
      chk8(v, {5'b10010, 3'(c)}, "done status");
      wr8(ARC_CTRL_OFS, 8'h10);
    end
    // alignment of a finished result
    wr8(ARC_MUX_OFS, 8'h43);
    wr8(ARC_CTRL_OFS, 8'hd0);
    meas(n);
    e = {4'h3, 2'b01, 4'h5};
    rd8(ARC_RES_LOW_OFS, v);
    chk8(v, e[7:0], "right low");
    rd8(ARC_RES_HIGH_OFS, v);
    chk8(v, {6'h00, e[9:8]}, "right high");
    wr8(ARC_MUX_OFS, 8'h63);
    rd8(ARC_RES_HIGH_OFS, v);
    chk8(v, e[9:2], "left high");
    rd8(ARC_RES_LOW_OFS, v);
    chk8(v, {e[1:0], 6'h00}, "left low");
    // a conversion ending while the pair is locked is lost
    wr8(ARC_MUX_OFS, 8'h67);
    wr8(ARC_CTRL_OFS, 8'hd0);
    meas(n);
    rd8(ARC_RES_HIGH_OFS, v);
    chk8(v, e[9:2], "locked high");
    // settings changed mid-conversion wait for its end
    wr8(ARC_CTRL_OFS, 8'hd0);
    wbusy();
    wr8(ARC_MUX_OFS, 8'he2);
    chk8({2'b00, ctl.ref_sel, ctl.channel}, 8'h17, "frozen settings");
    meas(n);
    repeat (2) @(posedge clk);
    chk8({2'b00, ctl.ref_sel, ctl.channel}, 8'h32, "late settings");
    e = {4'h7, 2'b01, 4'h5};
    rd8(ARC_RES_HIGH_OFS, v);
    chk8(v, e[9:2], "result of old channel");
    // abort by disabling in mid-conversion
    wr8(ARC_CTRL_OFS, 8'hd0);
    wbusy();
    rd8(ARC_CTRL_OFS, v);
    chk8(v, 8'hc0, "start reads busy");
    wr8(ARC_CTRL_OFS, 8'h00);
    repeat (3) @(posedge clk);
    rd8(ARC_CTRL_OFS, v);
    chk8({v[7:1], busy}, 8'h00, "aborted");
    chk8({6'h00, ctl.power, tick}, 8'h00, "powered down");
    // completion interrupt, its gating and its clearing
    wr8(ARC_CTRL_OFS, 8'hc8);
    meas(n);
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    chk8({7'h00, irq}, 8'h01, "irq raised");
    wr8(ARC_CTRL_OFS, 8'h88);
    rd8(ARC_CTRL_OFS, v);
    chk8(v, 8'h98, "zero keeps flag");
    gie <= 1'b0;
    repeat (2) @(posedge clk);
    chk8({7'h00, irq}, 8'h00, "irq gated");
    gie <= 1'b1;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (2) @(posedge clk);
    rd8(ARC_CTRL_OFS, v);
    chk8({v[7:1], irq}, 8'h88, "vector clears");
    wr8(ARC_CTRL_OFS, 8'hc8);
    meas(n);
    wr8(ARC_CTRL_OFS, 8'h98);
    rd8(ARC_CTRL_OFS, v);
    chk8(v, 8'h88, "one clears");
    // with auto trigger off a source edge starts nothing
    wr8(ARC_CTRL_OFS, 8'h00);
    wr8(ARC_CTRL_OFS, 8'h80);
    wr8(ARC_TRIG_OFS, 8'h02);
    trig[2] <= 1'b1;
    repeat (20) @(posedge clk);
    chk8({7'h00, busy}, 8'h00, "trigger ignored");
    trig[2] <= 1'b0;
    // auto trigger on each source's rising edge
    wr8(ARC_CTRL_OFS, 8'ha0);
    for (int c = 1; c < 8; c++) begin
      wr8(ARC_TRIG_OFS, {5'h00, 3'(c)});
      trig[c] <= 1'b1;
      meas(n);
      chk8(8'(n == ((c == 1) ? 50 : 26)), 8'h01, "triggered");
      trig[c] <= 1'b0;
    end
    trig[1] <= 1'b1;
    wr8(ARC_TRIG_OFS, 8'h01);
    meas(n);
    chk8(8'(n == 26), 8'h01, "switch is edge");
    wr8(ARC_TRIG_OFS, 8'h40);
    rd8(ARC_TRIG_OFS, v);
    repeat (20) @(posedge clk);
    chk8({v[7:1], busy}, 8'h40, "free code no trigger");
    // free running restarts with the current channel
    wr8(ARC_CTRL_OFS, 8'he0);
    wbusy();
    wr8(ARC_MUX_OFS, 8'h45);
    repeat (80) @(posedge clk);
    chk8({3'b000, busy, ctl.channel}, 8'h15, "free running");
    chk8({7'h00, ctl.power}, 8'h01, "core powered");
    // divide by two gives one tick every other cycle
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += tick;
    end
    chk8(8'(n), 8'd10, "tick rate");
    wr8(ARC_CTRL_OFS, 8'h00);
    // digital input disables
    wr8(ARC_DIS_OFS, 8'h15);
    rd8(ARC_DIS_OFS, v);
    chk8(v, 8'h15, "disable readback");
    chk8({boff, 2'b00}, 8'h54, "buffers off");
    chk8({pval, 2'b00}, 8'ha8, "pins read");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
